// ===== wdwu_pkg.sv
package wdwu_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses, one 32-bit word each)
   // ----------------------------------------------------------------
   localparam int          ADDR_W            = 8;
   localparam logic [7:0]  WATCHDOG_CONTROL_ADDR   = 8'h00;
   localparam logic [7:0]  SOFT_RESET_FLAG_ADDR    = 8'h04;
   localparam logic [7:0]  WAKE_STATUS_ADDR        = 8'h08;
   localparam logic [7:0]  SYSTEM_CLOCK_CTRL_ADDR  = 8'h0C;
   localparam logic [7:0]  PORT_A_WAKE_EN_ADDR     = 8'h10;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int          KEY_MSB           = 7;
   localparam int          KEY_LSB           = 3;
   localparam int          PERIOD_MSB        = 2;
   localparam int          PERIOD_LSB        = 0;
   localparam logic [7:0]  WATCHDOG_CONTROL_RESET        = 8'h53;
   localparam logic [4:0]  KEY_DISABLE       = 5'h15;
   localparam logic [4:0]  KEY_ENABLE        = 5'h0A;
   localparam int          KEY_RST_FLAG_BIT  = 0;
   localparam int          PDF_BIT           = 0;
   localparam int          TOF_BIT           = 1;
   localparam int          HALTED_BIT        = 2;
   localparam int          SLOW_KEEP_BIT     = 0;
   localparam int          FAST_KEEP_BIT     = 1;
   localparam logic [1:0]  SCC_RESET         = 2'h0;
   localparam logic [7:0]  PORT_A_WAKE_ENABLE_RESET        = 8'h00;
   localparam int          PORT_A_W          = 8;
   localparam int          IRQ_W             = 8;

   // ----------------------------------------------------------------
   // Watchdog period and timing
   // ----------------------------------------------------------------
   localparam int          WDT_CNT_W         = 16;
   localparam logic [3:0]  WDT_MIN_EXP       = 4'h8;
   localparam int          CLK_PERIOD_NS     = 50;
   localparam int          KEY_RESET_DELAY_NS = 1000;
   localparam int          KEY_RESET_DELAY_CYC =
      (KEY_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          DLY_W             = 8;

   // ----------------------------------------------------------------
   // AXI responses
   // ----------------------------------------------------------------
   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_SLVERR       = 2'h2;

   typedef enum logic [0:0] {
      MODE_RUN  = 1'b0,
      MODE_HALT = 1'b1
   } wdwu_mode_t;

endpackage

// ===== wdwu_top.sv
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module wdwu_top
   import wdwu_pkg::*;
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0]    s_axi_awaddr_i,
   input  wire logic                 s_axi_awvalid_i,
   output logic                      s_axi_awready_o,
   input  wire logic [31:0]          s_axi_wdata_i,
   input  wire logic [3:0]           s_axi_wstrb_i,
   input  wire logic                 s_axi_wvalid_i,
   output logic                      s_axi_wready_o,
   output logic [1:0]                s_axi_bresp_o,
   output logic                      s_axi_bvalid_o,
   input  wire logic                 s_axi_bready_i,
   input  wire logic [ADDR_W-1:0]    s_axi_araddr_i,
   input  wire logic                 s_axi_arvalid_i,
   output logic                      s_axi_arready_o,
   output logic [31:0]               s_axi_rdata_o,
   output logic [1:0]                s_axi_rresp_o,
   output logic                      s_axi_rvalid_o,
   input  wire logic                 s_axi_rready_i,
   // Core side
   input  wire logic                 halt_exec_i,
   input  wire logic                 wdt_clear_exec_i,
   input  wire logic [IRQ_W-1:0]     irq_req_i,
   // Pins
   input  wire logic                 low_speed_rc_osc_i,
   input  wire logic [PORT_A_W-1:0]  port_a_i,
   // Control outputs
   output logic                      cpu_halted_o,
   output logic                      fast_clk_en_o,
   output logic                      slow_clk_en_o,
   output logic                      wake_o,
   output logic                      pc_sp_reset_o,
   output logic                      device_reset_o
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic key_valid(input logic [4:0] key);
      key_valid = (key == KEY_ENABLE) || (key == KEY_DISABLE);
   endfunction
   function automatic logic [WDT_CNT_W-1:0] last_count(
      input logic [2:0] sel
   );
      logic [3:0] exp_v;
      exp_v = WDT_MIN_EXP + {1'b0, sel};
      last_count = (16'h0001 << exp_v) - 16'h0001;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   wdwu_mode_t                 mode_q;
   logic [7:0]                 watchdog_control_q;
   logic [1:0]                 scc_q;
   logic [PORT_A_W-1:0]        port_a_wake_enable_q;
   logic                       pdf_q;
   logic                       tof_q;
   logic                       key_rst_flag_q;
   logic [WDT_CNT_W-1:0]       cnt_q;
   logic                       pend_q;
   logic [DLY_W-1:0]           dly_q;
   logic [IRQ_W-1:0]           irq_block_q;
   logic                       low_speed_rc_osc_s1_q;
   logic                       low_speed_rc_osc_s2_q;
   logic                       low_speed_rc_osc_s3_q;
   logic [PORT_A_W-1:0]        pa_s1_q;
   logic [PORT_A_W-1:0]        pa_s2_q;
   logic [PORT_A_W-1:0]        pa_s3_q;
   logic                       fast_en_q;
   logic                       slow_en_q;
   logic                       wake_q;
   logic                       pcsp_q;
   logic                       devrst_q;
   logic                       awready_q;
   logic                       wready_q;
   logic                       bvalid_q;
   logic [1:0]                 bresp_q;
   logic [ADDR_W-1:0]          awaddr_q;
   logic [31:0]                wdata_q;
   logic [3:0]                 wstrb_q;
   logic                       arready_q;
   logic                       rvalid_q;
   logic [1:0]                 rresp_q;
   logic [31:0]                rdata_q;

   // ----------------------------------------------------------------
   // Event decode
   // ----------------------------------------------------------------
   logic                       low_speed_rc_osc_tick;
   logic                       wdt_on;
   logic                       cnt_run;
   logic                       ovf;
   logic                       halt_go;
   logic                       pa_wake;
   logic                       irq_wake;
   logic                       wake_any;
   logic                       key_bad;
   logic                       key_fire;
   logic                       full_rst;
   logic                       wr_go;
   logic                       wr_byte0;
   assign low_speed_rc_osc_tick = low_speed_rc_osc_s2_q & ~low_speed_rc_osc_s3_q;
   assign wdt_on    = watchdog_control_q[KEY_MSB:KEY_LSB] == KEY_ENABLE;
   assign cnt_run   = low_speed_rc_osc_tick & wdt_on & slow_en_q;
   assign ovf       = cnt_run &&
                      (cnt_q >= last_count(watchdog_control_q[PERIOD_MSB:PERIOD_LSB]));
   assign halt_go   = (mode_q == MODE_RUN) && halt_exec_i;
   assign pa_wake   = |(pa_s3_q & ~pa_s2_q & port_a_wake_enable_q);
   assign irq_wake  = |(irq_req_i & ~irq_block_q);
   assign wake_any  = (mode_q == MODE_HALT) && (pa_wake | irq_wake | ovf);
   assign key_bad   = ~key_valid(watchdog_control_q[KEY_MSB:KEY_LSB]);
   assign key_fire  = pend_q &&
                      (dly_q == DLY_W'(KEY_RESET_DELAY_CYC - 1));
   assign full_rst  = key_fire | (ovf && (mode_q == MODE_RUN));
   assign wr_go     = ~awready_q & ~wready_q & ~bvalid_q;
   assign wr_byte0  = wr_go & wstrb_q[0];

   // ----------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         low_speed_rc_osc_s1_q <= 1'b0;
         low_speed_rc_osc_s2_q <= 1'b0;
         low_speed_rc_osc_s3_q <= 1'b0;
         pa_s1_q   <= {PORT_A_W{1'b1}};
         pa_s2_q   <= {PORT_A_W{1'b1}};
         pa_s3_q   <= {PORT_A_W{1'b1}};
      end else begin
         low_speed_rc_osc_s1_q <= low_speed_rc_osc_i;
         low_speed_rc_osc_s2_q <= low_speed_rc_osc_s1_q;
         low_speed_rc_osc_s3_q <= low_speed_rc_osc_s2_q;
         pa_s1_q   <= port_a_i;
         pa_s2_q   <= pa_s1_q;
         pa_s3_q   <= pa_s2_q;
      end
   end

   // ----------------------------------------------------------------
   // Operating mode and clock enables
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || full_rst) begin
         mode_q    <= MODE_RUN;
         fast_en_q <= 1'b1;
         slow_en_q <= 1'b1;
      end else if (halt_go) begin
         mode_q    <= MODE_HALT;
         fast_en_q <= scc_q[FAST_KEEP_BIT];
         slow_en_q <= scc_q[SLOW_KEEP_BIT];
      end else if (wake_any) begin
         mode_q    <= MODE_RUN;
         fast_en_q <= 1'b1;
         slow_en_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_block_q <= '0;
      end else if (halt_go) begin
         irq_block_q <= irq_req_i;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_q   <= 1'b0;
         pcsp_q   <= 1'b0;
         devrst_q <= 1'b0;
      end else begin
         wake_q   <= wake_any;
         pcsp_q   <= ovf && (mode_q == MODE_HALT);
         devrst_q <= full_rst;
      end
   end

   // ----------------------------------------------------------------
   // Watchdog counter and key delay
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
      end else if (key_bad || wdt_clear_exec_i || halt_go) begin
         cnt_q <= '0;
      end else if (full_rst || ovf) begin
         cnt_q <= '0;
      end else if (cnt_run) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || key_fire) begin
         pend_q <= 1'b0;
         dly_q  <= '0;
      end else if (pend_q) begin
         dly_q  <= dly_q + 8'h01;
      end else if (key_bad) begin
         pend_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pdf_q <= 1'b0;
      end else if (halt_go) begin
         pdf_q <= 1'b1;
      end else if (wdt_clear_exec_i) begin
         pdf_q <= 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tof_q <= 1'b0;
      end else if (ovf) begin
         tof_q <= 1'b1;
      end else if (halt_go) begin
         tof_q <= 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         key_rst_flag_q <= 1'b0;
      end else if (key_fire) begin
         key_rst_flag_q <= 1'b1;
      end else if (wr_byte0 && (awaddr_q == SOFT_RESET_FLAG_ADDR) &&
                   !wdata_q[KEY_RST_FLAG_BIT]) begin
         key_rst_flag_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || full_rst) begin
         watchdog_control_q <= WATCHDOG_CONTROL_RESET;
      end else if (wr_byte0 && (awaddr_q == WATCHDOG_CONTROL_ADDR)) begin
         watchdog_control_q <= wdata_q[7:0];
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || full_rst) begin
         scc_q  <= SCC_RESET;
         port_a_wake_enable_q <= PORT_A_WAKE_ENABLE_RESET;
      end else if (wr_byte0) begin
         if (awaddr_q == SYSTEM_CLOCK_CTRL_ADDR) begin
            scc_q <= wdata_q[1:0];
         end
         if (awaddr_q == PORT_A_WAKE_EN_ADDR) begin
            port_a_wake_enable_q <= wdata_q[PORT_A_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
      end else begin
         if (awready_q && s_axi_awvalid_i) begin
            awready_q <= 1'b0;
            awaddr_q  <= s_axi_awaddr_i;
         end
         if (wready_q && s_axi_wvalid_i) begin
            wready_q <= 1'b0;
            wdata_q  <= s_axi_wdata_i;
            wstrb_q  <= s_axi_wstrb_i;
         end
         if (wr_go) begin
            bvalid_q <= 1'b1;
            case (awaddr_q)
               WATCHDOG_CONTROL_ADDR,
               SOFT_RESET_FLAG_ADDR,
               WAKE_STATUS_ADDR,
               SYSTEM_CLOCK_CTRL_ADDR,
               PORT_A_WAKE_EN_ADDR: bresp_q <= RESP_OKAY;
               default:             bresp_q <= RESP_SLVERR;
            endcase
         end
         if (bvalid_q && s_axi_bready_i) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rresp_q   <= RESP_OKAY;
         rdata_q   <= '0;
      end else if (arready_q && s_axi_arvalid_i) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rresp_q   <= RESP_OKAY;
         rdata_q   <= '0;
         case (s_axi_araddr_i)
            WATCHDOG_CONTROL_ADDR:  rdata_q[7:0] <= watchdog_control_q;
            SOFT_RESET_FLAG_ADDR:
               rdata_q[KEY_RST_FLAG_BIT] <= key_rst_flag_q;
            WAKE_STATUS_ADDR: begin
               rdata_q[PDF_BIT]    <= pdf_q;
               rdata_q[TOF_BIT]    <= tof_q;
               rdata_q[HALTED_BIT] <= (mode_q == MODE_HALT);
            end
            SYSTEM_CLOCK_CTRL_ADDR: rdata_q[1:0] <= scc_q;
            PORT_A_WAKE_EN_ADDR:    rdata_q[PORT_A_W-1:0] <= port_a_wake_enable_q;
            default:                rresp_q <= RESP_SLVERR;
         endcase
      end else if (rvalid_q && s_axi_rready_i) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axi_awready_o = awready_q;
   assign s_axi_wready_o  = wready_q;
   assign s_axi_bvalid_o  = bvalid_q;
   assign s_axi_bresp_o   = bresp_q;
   assign s_axi_arready_o = arready_q;
   assign s_axi_rvalid_o  = rvalid_q;
   assign s_axi_rresp_o   = rresp_q;
   assign s_axi_rdata_o   = rdata_q;
   assign cpu_halted_o    = mode_q == MODE_HALT;
   assign fast_clk_en_o   = fast_en_q;
   assign slow_clk_en_o   = slow_en_q;
   assign wake_o          = wake_q;
   assign pc_sp_reset_o   = pcsp_q;
   assign device_reset_o  = devrst_q;

endmodule

// ===== wdwu_chk_assertions.sv
`timescale 1ns/100ps
module wdwu_chk
   import wdwu_pkg::*;
(
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   input  wire logic  s_axi_awvalid_i,
   input  wire logic  s_axi_awready_o,
   input  wire logic  s_axi_wvalid_i,
   input  wire logic  s_axi_wready_o,
   input  wire logic  s_axi_bvalid_o,
   input  wire logic  s_axi_arvalid_i,
   input  wire logic  s_axi_arready_o,
   input  wire logic  s_axi_rvalid_o,
   input  wire logic  halt_exec_i,
   input  wire logic  cpu_halted_o,
   input  wire logic  fast_clk_en_o,
   input  wire logic  slow_clk_en_o,
   input  wire logic  wake_o,
   input  wire logic  pc_sp_reset_o,
   input  wire logic  device_reset_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // ----------------------------------------------------------------
   // Steps
   // ----------------------------------------------------------------
   sequence halt_taken;
      !cpu_halted_o && halt_exec_i;
   endsequence
   sequence aw_w_taken;
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
   endsequence
   sequence ar_taken;
      s_axi_arvalid_i && s_axi_arready_o;
   endsequence

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   AST_HALT_ENTER: assert property (halt_taken |=> cpu_halted_o)
      else $error("halt not entered");
   AST_CLK_HOLD: assert property (
      cpu_halted_o && $past(cpu_halted_o)
      |-> $stable({fast_clk_en_o, slow_clk_en_o}))
      else $error("clock keep changed while halted");
   AST_WAKE_FALL: assert property (wake_o |-> $fell(cpu_halted_o))
      else $error("wake without leaving halt");
   AST_FALL_WAKE: assert property ($fell(cpu_halted_o) |-> wake_o)
      else $error("halt left without wake");
   AST_WAKE_PULSE: assert property (wake_o |=> !wake_o)
      else $error("wake longer than one cycle");
   AST_PCSP_WAKE: assert property (pc_sp_reset_o
      |-> wake_o && !device_reset_o)
      else $error("halted overflow not a plain wake");
   AST_DEVRST_PULSE: assert property (
      device_reset_o |=> !device_reset_o)
      else $error("device reset longer than one cycle");
   AST_W_ANS: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid_o)
      else $error("write response late");
   AST_AR_ANS: assert property (ar_taken |=> s_axi_rvalid_o)
      else $error("read data late");
   AST_AW_BLOCK: assert property (s_axi_bvalid_o
      |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("write accepted during response");
endmodule

bind wdwu_top wdwu_chk chk_u (
   .clk_i(clk_i), .rst_i(rst_i),
   .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
   .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
   .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_arvalid_i(s_axi_arvalid_i),
   .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
   .halt_exec_i(halt_exec_i), .cpu_halted_o(cpu_halted_o),
   .fast_clk_en_o(fast_clk_en_o), .slow_clk_en_o(slow_clk_en_o),
   .wake_o(wake_o), .pc_sp_reset_o(pc_sp_reset_o),
   .device_reset_o(device_reset_o)
);

// ===== testbench.sv
`timescale 1ns/100ps
`define CHK(got, exp) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) begin \
         err_count++; \
         $display("BAD %0t got %h expected %h", $time, got, exp); \
      end \
   end
module testbench
   import wdwu_pkg::*;
;
   logic                 clk_i = 1'b0, rst_i = 1'b1;
   logic [ADDR_W-1:0]    s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
   logic                 s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
   logic                 s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
   logic                 s_axi_rready_i = 1'b0;
   logic [31:0]          s_axi_wdata_i = '0, s_axi_rdata_o;
   logic [3:0]           s_axi_wstrb_i = 4'hF;
   logic [1:0]           s_axi_bresp_o, s_axi_rresp_o;
   logic                 s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
   logic                 s_axi_arready_o, s_axi_rvalid_o;
   logic                 halt_exec_i = 1'b0, wdt_clear_exec_i = 1'b0;
   logic [IRQ_W-1:0]     irq_req_i = '0;
   logic                 low_speed_rc_osc_i = 1'b0;
   logic [PORT_A_W-1:0]  port_a_i = 8'hFF;
   logic                 cpu_halted_o, fast_clk_en_o, slow_clk_en_o;
   logic                 wake_o, pc_sp_reset_o, device_reset_o;
   logic [1:0]           slow_div = 2'h0;
   int                   err_count = 0, samples_checked = 0;

   wdwu_top dut_u (.clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
      .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
      .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
      .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
      .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .halt_exec_i,
      .wdt_clear_exec_i, .irq_req_i, .low_speed_rc_osc_i, .port_a_i,
      .cpu_halted_o, .fast_clk_en_o, .slow_clk_en_o, .wake_o,
      .pc_sp_reset_o, .device_reset_o);

   initial begin
      forever #25 clk_i = ~clk_i;
   end

   // Slow clock: one rising edge every four cycles
   always @(posedge clk_i) begin
      slow_div <= slow_div + 2'h1;
      low_speed_rc_osc_i <= slow_div[1];
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task end_of_test;
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task hang;
      err_count++;
      $display("BAD %0t wait ran out", $time);
      end_of_test();
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
         if (s_axi_bvalid_o) begin
            s_axi_bready_i <= 1'b0;
            break;
         end
      end
      if (n == 100) hang();
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp,
                     input logic [1:0] resp);
      int n;
      @(posedge clk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk_i);
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
         if (s_axi_rvalid_o) begin
            `CHK(s_axi_rdata_o, exp)
            `CHK(s_axi_rresp_o, resp)
            s_axi_rready_i <= 1'b0;
            break;
         end
      end
      if (n == 100) hang();
   endtask

   task automatic pulse(input bit halt);
      @(posedge clk_i);
      if (halt) halt_exec_i <= 1'b1;
      else wdt_clear_exec_i <= 1'b1;
      @(posedge clk_i);
      halt_exec_i <= 1'b0;
      wdt_clear_exec_i <= 1'b0;
   endtask

   // Which: 0 device reset, 1 pc/sp reset, 2 wake
   task automatic wait_pulse(input int which, input int lim, output int n);
      for (n = 1; n <= lim; n++) begin
         @(posedge clk_i);
         if (which == 0 && device_reset_o === 1'b1) return;
         if (which == 1 && pc_sp_reset_o === 1'b1) return;
         if (which == 2 && wake_o === 1'b1) return;
      end
      hang();
   endtask

   task automatic quiet(input int lim);
      repeat (lim) begin
         @(posedge clk_i);
         `CHK(device_reset_o | wake_o, 1'b0)
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_reset_values;
      rd(WATCHDOG_CONTROL_ADDR, 32'h0000_0053, RESP_OKAY);
      rd(SOFT_RESET_FLAG_ADDR, 32'h0000_0000, RESP_OKAY);
      rd(WAKE_STATUS_ADDR, 32'h0000_0000, RESP_OKAY);
      rd(8'h20, 32'h0000_0000, RESP_SLVERR);
      wr(8'h24, 32'h0000_0001);
      `CHK(s_axi_bresp_o, RESP_SLVERR)
   endtask

   task automatic t_timeout_run;
      int n;
      for (int s = 0; s < 2; s++) begin
         wr(WATCHDOG_CONTROL_ADDR, {24'h00_0000, KEY_ENABLE, 3'(s)});
         pulse(1'b0);
         repeat (800) @(posedge clk_i);
         pulse(1'b0);
         wait_pulse(0, 4500, n);
         `CHK(n > (1024 << s) - 9 && n < (1024 << s) + 9, 1'b1)
         rd(WAKE_STATUS_ADDR, 32'h0000_0002, RESP_OKAY);
         rd(WATCHDOG_CONTROL_ADDR, 32'h0000_0053, RESP_OKAY);
      end
   endtask

   task automatic t_halt_port;
      int n;
      wr(SYSTEM_CLOCK_CTRL_ADDR, 32'h0000_0002);
      wr(PORT_A_WAKE_EN_ADDR, 32'h0000_0001);
      pulse(1'b1);
      @(posedge clk_i);
      `CHK({cpu_halted_o, fast_clk_en_o, slow_clk_en_o}, 3'b110)
      rd(WAKE_STATUS_ADDR, 32'h0000_0005, RESP_OKAY);
      port_a_i <= 8'hFD;
      quiet(10);
      port_a_i <= 8'hFC;
      wait_pulse(2, 10, n);
      `CHK(n <= 5, 1'b1)
      port_a_i <= 8'hFF;
      pulse(1'b0);
      rd(WAKE_STATUS_ADDR, 32'h0000_0000, RESP_OKAY);
   endtask

   task automatic t_irq;
      int n;
      irq_req_i <= 8'h01;
      pulse(1'b1);
      quiet(20);
      irq_req_i <= 8'h03;
      wait_pulse(2, 10, n);
      `CHK(cpu_halted_o, 1'b0)
      irq_req_i <= 8'h00;
   endtask

   task automatic t_halt_overflow;
      int n;
      wr(WATCHDOG_CONTROL_ADDR, {24'h00_0000, KEY_ENABLE, 3'b000});
      wr(SYSTEM_CLOCK_CTRL_ADDR, 32'h0000_0001);
      pulse(1'b0);
      repeat (400) @(posedge clk_i);
      pulse(1'b1);
      wait_pulse(1, 1200, n);
      `CHK(n > 1010 && n < 1040, 1'b1)
      rd(WAKE_STATUS_ADDR, 32'h0000_0003, RESP_OKAY);
      rd(WATCHDOG_CONTROL_ADDR, 32'h0000_0050, RESP_OKAY);
   endtask

   task automatic t_bad_key;
      int n;
      wr(WATCHDOG_CONTROL_ADDR, 32'h0000_00FB);
      wait_pulse(0, 60, n);
      n = n - KEY_RESET_DELAY_CYC;
      `CHK(n > -5 && n < 5, 1'b1)
      rd(SOFT_RESET_FLAG_ADDR, 32'h0000_0001, RESP_OKAY);
      wr(SOFT_RESET_FLAG_ADDR, 32'h0000_0001);
      rd(SOFT_RESET_FLAG_ADDR, 32'h0000_0001, RESP_OKAY);
      wr(SOFT_RESET_FLAG_ADDR, 32'h0000_00FE);
      rd(SOFT_RESET_FLAG_ADDR, 32'h0000_0000, RESP_OKAY);
   endtask

   task t_disable;
      wr(WATCHDOG_CONTROL_ADDR, {24'h00_0000, KEY_DISABLE, 3'b000});
      pulse(1'b0);
      quiet(1300);
      rd(WATCHDOG_CONTROL_ADDR, 32'h0000_00A8, RESP_OKAY);
   endtask

   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset_values();
      t_timeout_run();
      t_halt_port();
      t_irq();
      t_halt_overflow();
      t_bad_key();
      t_disable();
      end_of_test();
   end
endmodule
